// >>> hdl/mmd_pkg.sv
// Constants for the memory map decoder: address
// windows, special register map and field layout.
// Assumes an 8-bit core on one 100 MHz clock.
package mmd_pkg;

  // ----------------------------------------------
  // Program space
  // ----------------------------------------------
  localparam logic [15:0] PM_TOP_BASE  = 16'hFC00;
  localparam int          PM_ROM_AW    = 10;
  localparam int          NVM_AW       = 17;
  localparam logic [1:0]  NVM_HI_BANK  = 2'h2;
  localparam logic [1:0]  BANK_ONE     = 2'h1;

  // ----------------------------------------------
  // External data windows (base and last)
  // ----------------------------------------------
  localparam logic [15:0] XD_RAM_LO  = 16'h0000;
  localparam logic [15:0] XD_RAM_HI  = 16'h1FFF;
  localparam logic [15:0] XD_MACR_LO = 16'h2000;
  localparam logic [15:0] XD_MACR_HI = 16'h21FF;
  localparam logic [15:0] XD_PHY_LO  = 16'h2200;
  localparam logic [15:0] XD_PHY_HI  = 16'h22FF;
  localparam logic [15:0] XD_MACB_LO = 16'h2300;
  localparam logic [15:0] XD_MACB_HI = 16'h24FF;
  localparam logic [15:0] XD_PER_LO  = 16'h2500;
  localparam logic [15:0] XD_PER_HI  = 16'h27FF;

  // ----------------------------------------------
  // Internal register area
  // ----------------------------------------------
  localparam int         IRAM_N       = 128;
  localparam logic [7:0] BIT_AREA_LO  = 8'h20;
  localparam logic [7:0] SCRATCH_LO   = 8'h30;
  localparam int         PSW_RS_LSB   = 3;
  localparam int         CODE_MAP_CONTROL_ISP_BIT = 2;
  localparam int         CODE_MAP_CONTROL_ROM_BIT = 1;
  localparam logic [1:0] MODE_ISP     = 2'h3;

  // Kinds of internal access
  typedef enum logic [1:0] {
    MMD_DIRECT, MMD_INDIRECT, MMD_WORKREG, MMD_BIT
  } mmd_kind_t;

  // ----------------------------------------------
  // Special registers, index order
  // ----------------------------------------------
  localparam int SFR_N = 39;
  localparam logic [7:0] SFR_ADDR [SFR_N] = '{
    8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85,
    8'h87, 8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C,
    8'h8D, 8'h90, 8'h91, 8'hA1, 8'hA2, 8'hA8,
    8'hA9, 8'hAA, 8'hAB, 8'hAC, 8'hAD, 8'hB0,
    8'hB1, 8'hB2, 8'hB4, 8'hB8, 8'hB9, 8'hBA,
    8'hBC, 8'hC0, 8'hD0, 8'hD2, 8'hD8, 8'hE0,
    8'hE8, 8'hF0, 8'hF8};
  // Overlay bit of code_map_control resets set
  localparam logic [7:0] SFR_RST [SFR_N] = '{
    8'hFF, 8'h07, 8'h00, 8'h00, 8'hFF, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3F,
    8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF,
    8'hFF, 8'h02, 8'h00, 8'h0B, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00};
  // Indices the decoder itself looks at
  localparam int IDX_CODE_BANK  = 15;
  localparam int IDX_PTR_SEL    = 16;
  localparam int IDX_CODE_MAP   = 31;
  localparam int IDX_PSW        = 32;
  localparam logic [7:0] WMASK_CODE_MAP  = 8'h02;
  localparam logic [7:0] WMASK_CODE_BANK = 8'h03;
  localparam logic [7:0] WMASK_PTR_SEL   = 8'h01;

endpackage

// >>> hdl/mmd_fetch_map.sv
// Program-space mapping of fetch addresses.
// Assumes overlay and bank inputs are registers.
`timescale 1ns/100ps
module mmd_fetch_map import mmd_pkg::*; (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Fetch request
  input  wire logic              fetch_req,
  input  wire logic [15:0]       fetch_addr,
  // Mapping controls
  input  wire logic              rom_overlay_select,
  input  wire logic [1:0]        code_bank_select,
  // Mapped fetch
  output logic                   fetch_ack_q,
  output logic                   rom_sel_q,
  output logic                   nvm_sel_q,
  output logic [PM_ROM_AW-1:0]   rom_addr_q,
  output logic [NVM_AW-1:0]      nvm_addr_q
);

  // ----------------------------------------------
  // Decode
  // ----------------------------------------------
  // Top 1KB picks one overlaid source only
  logic              in_top;
  logic              use_rom;
  logic              hi_bank;
  logic [NVM_AW-1:0] phys;
  assign in_top  = fetch_addr >= PM_TOP_BASE;
  assign use_rom = in_top & rom_overlay_select;
  // Bank 1 moves the upper half only
  assign hi_bank = (code_bank_select == BANK_ONE) & fetch_addr[15];
  assign phys    = hi_bank ? {NVM_HI_BANK, fetch_addr[14:0]}
                           : {1'b0, fetch_addr};

  // ----------------------------------------------
  // Capture
  // ----------------------------------------------
  // Controls sampled with the request, so a later
  // write cannot disturb a fetch already taken
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fetch_ack_q <= 1'b0;
      rom_sel_q   <= 1'b0;
      nvm_sel_q   <= 1'b0;
      rom_addr_q  <= '0;
      nvm_addr_q  <= '0;
    end else begin
      fetch_ack_q <= fetch_req;
      if (fetch_req) begin
        rom_sel_q  <= use_rom;
        nvm_sel_q  <= ~use_rom;
        rom_addr_q <= fetch_addr[PM_ROM_AW-1:0];
        nvm_addr_q <= phys;
      end
    end
  end

endmodule

// >>> hdl/mmd_xdata_dec.sv
// External data space window decoder.
// Assumes the core raises xdata_req only for an
// external data move.
`timescale 1ns/100ps
module mmd_xdata_dec import mmd_pkg::*; (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Request
  input  wire logic        xdata_req,
  input  wire logic [15:0] xdata_addr,
  // Window selects
  output logic             xdata_ack_q,
  output logic             sel_ram_q,
  output logic             sel_mac_reg_q,
  output logic             sel_phy_q,
  output logic             sel_mac_buf_q,
  output logic             sel_periph_q,
  output logic             sel_none_q,
  output logic [15:0]      xdata_off_q
);

  // Range test shared by every window
  function automatic logic in_win(
    input logic [15:0] a, lo, hi);
    in_win = (a >= lo) && (a <= hi);
  endfunction

  // ----------------------------------------------
  // Decode
  // ----------------------------------------------
  logic        w_ram, w_macr, w_phy, w_macb, w_per;
  logic [15:0] base;
  assign w_ram  = in_win(xdata_addr, XD_RAM_LO, XD_RAM_HI);
  assign w_macr = in_win(xdata_addr, XD_MACR_LO, XD_MACR_HI);
  assign w_phy  = in_win(xdata_addr, XD_PHY_LO, XD_PHY_HI);
  assign w_macb = in_win(xdata_addr, XD_MACB_LO, XD_MACB_HI);
  assign w_per  = in_win(xdata_addr, XD_PER_LO, XD_PER_HI);
  assign base   = w_macr ? XD_MACR_LO : w_phy ? XD_PHY_LO :
                  w_macb ? XD_MACB_LO : w_per ? XD_PER_LO : XD_RAM_LO;

  // ----------------------------------------------
  // Capture
  // ----------------------------------------------
  // Selects only move on a request; between
  // requests they hold the last decode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      xdata_ack_q   <= 1'b0;
      sel_ram_q     <= 1'b0;
      sel_mac_reg_q <= 1'b0;
      sel_phy_q     <= 1'b0;
      sel_mac_buf_q <= 1'b0;
      sel_periph_q  <= 1'b0;
      sel_none_q    <= 1'b0;
      xdata_off_q   <= '0;
    end else begin
      xdata_ack_q <= xdata_req;
      if (xdata_req) begin
        sel_ram_q     <= w_ram;
        sel_mac_reg_q <= w_macr;
        sel_phy_q     <= w_phy;
        sel_mac_buf_q <= w_macb;
        sel_periph_q  <= w_per;
        sel_none_q    <= ~(w_ram | w_macr | w_phy | w_macb | w_per);
        xdata_off_q   <= xdata_addr - base;
      end
    end
  end

endmodule

// >>> hdl/mmd_decoder.sv
// Memory map decoder top: internal register area,
// special register file, program and external
// data mapping.
// Assumes one access per cycle from the core and
// mode-select pins synchronous to clk.
//
// Notes on behaviour
// - Program space is 64KB; lower 63KB always come from non-volatile memory.
// - Top 1KB served by either non-volatile memory or boot ROM, never both.
// - After power-up the top 1KB fetches come from the boot ROM.
// - Overlay bit written 0 maps the top 1KB to non-volatile memory.
// - Upper 64KB of the 96KB array splits in two 32KB banks.
// - Bank field 0 maps program space onto the lowest 64KB linearly.
// - Bank field 1 maps upper half of program space to highest 32KB.
// - External data space is 64KB, reached only by external data moves.
// - External 0x0000 to 0x1FFF selects the application data RAM.
// - 0x2000-0x21FF selects MAC registers, 0x2300-0x24FF MAC buffer.
// - 0x2200 to 0x22FF selects the radio PHY registers.
// - 0x2500 to 0x27FF selects the peripheral control registers.
// - Bytes 0x00-0x1F are four banks of eight working registers.
// - Reset selects working register bank 0.
// - Bytes 0x20-0x2F also reachable as bits 0 to 127.
// - Bytes 0x30 to 0x7F are scratch RAM.
// - Internal area supports direct and indirect addressing.
// - Special registers are byte access; multiples of 8 also bitwise.
// - In-system-programming flag set when both mode pins read high.
`timescale 1ns/100ps
module mmd_decoder import mmd_pkg::*; (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Straps
  input  wire logic [1:0]        mode_select_pins,
  // Internal access from the core
  input  wire logic              acc_req,
  input  wire logic              acc_we,
  input  wire mmd_kind_t         acc_kind,
  input  wire logic [7:0]        acc_addr,
  input  wire logic [7:0]        acc_wdata,
  // Internal access answer
  output logic                   acc_ack_q,
  output logic [7:0]             acc_rdata_q,
  output logic                   acc_miss_q,
  // Fetch request
  input  wire logic              fetch_req,
  input  wire logic [15:0]       fetch_addr,
  // Fetch answer
  output logic                   fetch_ack_q,
  output logic                   rom_sel_q,
  output logic                   nvm_sel_q,
  output logic [PM_ROM_AW-1:0]   rom_addr_q,
  output logic [NVM_AW-1:0]      nvm_addr_q,
  // External data request
  input  wire logic              xdata_req,
  input  wire logic [15:0]       xdata_addr,
  // External data selects
  output logic                   xdata_ack_q,
  output logic                   sel_ram_q,
  output logic                   sel_mac_reg_q,
  output logic                   sel_phy_q,
  output logic                   sel_mac_buf_q,
  output logic                   sel_periph_q,
  output logic                   sel_none_q,
  output logic [15:0]            xdata_off_q,
  // Mapping state seen by the core
  output logic [1:0]             working_bank_select_q,
  output logic                   pointer_sel_q,
  output logic                   in_system_prog_flag_q
);

  // ----------------------------------------------
  // Helper functions
  // ----------------------------------------------
  // Special register lookup: hit flag and index
  function automatic logic [6:0] sfr_find(
    input logic [7:0] a);
    sfr_find = '0;
    for (int i = 0; i < SFR_N; i++) begin
      if (SFR_ADDR[i] == a) begin
        sfr_find = {1'b1, i[5:0]};
      end
    end
  endfunction

  // Writable bits per register; fixed bits keep
  // their value whatever software writes
  function automatic logic [7:0] sfr_wmask(
    input logic [5:0] idx);
    if (idx == 6'(IDX_CODE_MAP)) begin
      sfr_wmask = WMASK_CODE_MAP;
    end else if (idx == 6'(IDX_CODE_BANK)) begin
      sfr_wmask = WMASK_CODE_BANK;
    end else if (idx == 6'(IDX_PTR_SEL)) begin
      sfr_wmask = WMASK_PTR_SEL;
    end else begin
      sfr_wmask = 8'hFF;
    end
  endfunction

  // Replace one bit of a byte
  function automatic logic [7:0] put_bit(
    input logic [7:0] b,
    input logic [2:0] pos,
    input logic       v);
    put_bit      = b;
    put_bit[pos] = v;
  endfunction

  // ----------------------------------------------
  // Storage
  // ----------------------------------------------
  logic [7:0] iram_q [IRAM_N];
  logic [7:0] sfr_q  [SFR_N];
  logic       isp_q;

  // ----------------------------------------------
  // Live control fields
  // ----------------------------------------------
  logic [1:0] rs;
  logic       overlay;
  logic [1:0] bank;
  assign rs      = sfr_q[IDX_PSW][PSW_RS_LSB+1:PSW_RS_LSB];
  assign overlay = sfr_q[IDX_CODE_MAP][CODE_MAP_CONTROL_ROM_BIT];
  // Values 2 and 3 are stored but map like bank 0
  assign bank    = sfr_q[IDX_CODE_BANK][1:0];

  // ----------------------------------------------
  // Target byte address
  // ----------------------------------------------
  // Working registers go through the bank field;
  // bit numbers fold onto their owning byte
  logic       is_bit;
  logic       bit_sfr;
  logic [7:0] bit_byte;
  logic [7:0] tgt;
  logic       tgt_sfr;
  assign is_bit   = acc_kind == MMD_BIT;
  assign bit_sfr  = acc_addr[7];
  assign bit_byte = bit_sfr ? {acc_addr[7:3], 3'h0}
                            : BIT_AREA_LO + {4'h0, acc_addr[6:3]};
  assign tgt = (acc_kind == MMD_WORKREG) ? {3'h0, rs, acc_addr[2:0]}
             : is_bit ? bit_byte : acc_addr;
  // Indirect access never reaches special registers
  assign tgt_sfr = tgt[7] & (acc_kind != MMD_INDIRECT);

  // ----------------------------------------------
  // Hit and current value
  // ----------------------------------------------
  logic [6:0] found;
  logic [5:0] sidx;
  logic       sfr_hit;
  logic       iram_hit;
  logic       hit;
  logic [7:0] sfr_val;
  logic [7:0] cur;
  assign found    = sfr_find(tgt);
  assign sidx     = found[5:0];
  assign sfr_hit  = tgt_sfr & found[6];
  // Upper indirect half has no memory behind it
  assign iram_hit = ~tgt[7];
  assign hit      = tgt_sfr ? sfr_hit : iram_hit;
  // Flag bit is live, merged in on every read
  assign sfr_val  = (sidx == 6'(IDX_CODE_MAP))
                  ? (sfr_q[sidx] | {5'h0, isp_q, 2'h0})
                  : sfr_q[sidx];
  assign cur = !hit ? 8'h00
             : tgt_sfr ? sfr_val : iram_q[tgt[6:0]];

  // ----------------------------------------------
  // Write value
  // ----------------------------------------------
  // Bit writes are read-modify-write of the byte
  logic [7:0] raw_new;
  logic [7:0] wm;
  logic [7:0] new_byte;
  logic       do_wr;
  logic       wr_sfr;
  logic       wr_iram;
  assign raw_new  = is_bit ? put_bit(cur, acc_addr[2:0], acc_wdata[0])
                           : acc_wdata;
  assign wm       = tgt_sfr ? sfr_wmask(sidx) : 8'hFF;
  assign new_byte = (raw_new & wm) | (sfr_q[sidx] & ~wm);
  assign do_wr    = acc_req & acc_we & hit;
  assign wr_sfr   = do_wr & tgt_sfr;
  assign wr_iram  = do_wr & ~tgt_sfr;

  // ----------------------------------------------
  // Read value
  // ----------------------------------------------
  logic [7:0] rd_val;
  assign rd_val = is_bit ? {7'h00, cur[acc_addr[2:0]]} : cur;

  // ----------------------------------------------
  // Internal RAM
  // ----------------------------------------------
  // Cleared at reset so reads are never unknown
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < IRAM_N; i++) begin
        iram_q[i] <= 8'h00;
      end
    end else if (wr_iram) begin
      iram_q[tgt[6:0]] <= new_byte;
    end
  end

  // ----------------------------------------------
  // Special register file
  // ----------------------------------------------
  // Reset values come from the table; program
  // status word clears, picking bank 0
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < SFR_N; i++) begin
        sfr_q[i] <= SFR_RST[i];
      end
    end else if (wr_sfr) begin
      sfr_q[sidx] <= new_byte;
    end
  end

  // ----------------------------------------------
  // Mode pin flag
  // ----------------------------------------------
  // Tracks the pins; not writable by software
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      isp_q <= 1'b0;
    end else begin
      isp_q <= mode_select_pins == MODE_ISP;
    end
  end

  // ----------------------------------------------
  // Access answer
  // ----------------------------------------------
  // Miss reads as zero and writes nothing
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_ack_q   <= 1'b0;
      acc_rdata_q <= 8'h00;
      acc_miss_q  <= 1'b0;
    end else begin
      acc_ack_q  <= acc_req;
      acc_miss_q <= acc_req & ~hit;
      if (acc_req) begin
        acc_rdata_q <= rd_val;
      end
    end
  end

  // ----------------------------------------------
  // Mirrored control outputs
  // ----------------------------------------------
  // Copies kept so every output is a flop; they
  // lag the register file by one cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      working_bank_select_q <= 2'h0;
      pointer_sel_q         <= 1'b0;
      in_system_prog_flag_q <= 1'b0;
    end else begin
      working_bank_select_q <= rs;
      pointer_sel_q         <= sfr_q[IDX_PTR_SEL][0];
      in_system_prog_flag_q <= isp_q;
    end
  end

  // ----------------------------------------------
  // Program space mapping
  // ----------------------------------------------
  mmd_fetch_map u_fetch (
    .clk                (clk),
    .rst_n              (rst_n),
    .fetch_req          (fetch_req),
    .fetch_addr         (fetch_addr),
    .rom_overlay_select (overlay),
    .code_bank_select   (bank),
    .fetch_ack_q        (fetch_ack_q),
    .rom_sel_q          (rom_sel_q),
    .nvm_sel_q          (nvm_sel_q),
    .rom_addr_q         (rom_addr_q),
    .nvm_addr_q         (nvm_addr_q)
  );

  // ----------------------------------------------
  // External data decode
  // ----------------------------------------------
  mmd_xdata_dec u_xdata (
    .clk           (clk),
    .rst_n         (rst_n),
    .xdata_req     (xdata_req),
    .xdata_addr    (xdata_addr),
    .xdata_ack_q   (xdata_ack_q),
    .sel_ram_q     (sel_ram_q),
    .sel_mac_reg_q (sel_mac_reg_q),
    .sel_phy_q     (sel_phy_q),
    .sel_mac_buf_q (sel_mac_buf_q),
    .sel_periph_q  (sel_periph_q),
    .sel_none_q    (sel_none_q),
    .xdata_off_q   (xdata_off_q)
  );

endmodule

// >>> verif/mmd_decoder_props.sv
// Checker for the memory map decoder top.
// Assumes binding into mmd_decoder; sees ports only.
`timescale 1ns/100ps
module mmd_decoder_props import mmd_pkg::*; (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 rst_n,
  // Requests
  input wire logic [1:0]           mode_select_pins,
  input wire logic                 acc_req,
  input wire logic                 fetch_req,
  input wire logic [15:0]          fetch_addr,
  input wire logic                 xdata_req,
  input wire logic [15:0]          xdata_addr,
  // Answers
  input wire logic                 acc_ack_q,
  input wire logic                 acc_miss_q,
  input wire logic                 fetch_ack_q,
  input wire logic                 rom_sel_q,
  input wire logic                 nvm_sel_q,
  input wire logic [PM_ROM_AW-1:0] rom_addr_q,
  input wire logic                 sel_ram_q,
  input wire logic                 sel_mac_reg_q,
  input wire logic                 sel_phy_q,
  input wire logic                 sel_periph_q,
  input wire logic                 sel_none_q,
  input wire logic [15:0]          xdata_off_q,
  input wire logic                 in_system_prog_flag_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------
  // Handshakes and program space
  // ----------------------------------------------
  a_acc_ack_timing: assert property (acc_ack_q == $past(acc_req))
    else $error("access answer not one cycle after request");
  a_miss_with_ack: assert property (acc_miss_q |-> acc_ack_q)
    else $error("miss flag without answer");
  a_fetch_ack_timing: assert property (fetch_ack_q == $past(fetch_req))
    else $error("fetch answer not one cycle after request");
  a_low_space_nvm: assert property (fetch_req && fetch_addr < PM_TOP_BASE |=> nvm_sel_q && !rom_sel_q)
    else $error("low program space not served by non-volatile memory");
  a_top_one_source: assert property (fetch_ack_q |-> rom_sel_q ^ nvm_sel_q)
    else $error("program source selects not one-hot");
  a_rom_offset: assert property (fetch_req |=> rom_addr_q == PM_ROM_AW'($past(fetch_addr)))
    else $error("boot ROM offset wrong");
  // ----------------------------------------------
  // External data windows and straps
  // ----------------------------------------------
  a_ram_window: assert property (xdata_req && xdata_addr <= XD_RAM_HI |=>
    sel_ram_q && xdata_off_q == $past(xdata_addr)) else $error("data RAM window wrong");
  a_mac_window: assert property (xdata_req && xdata_addr inside {[XD_MACR_LO:XD_MACR_HI]}
    |=> sel_mac_reg_q && !sel_none_q) else $error("MAC register window wrong");
  a_phy_window: assert property (xdata_req && xdata_addr inside {[XD_PHY_LO:XD_PHY_HI]} |=>
    sel_phy_q && xdata_off_q == $past(xdata_addr) - XD_PHY_LO) else $error("PHY window wrong");
  a_periph_window: assert property (xdata_req && xdata_addr inside {[XD_PER_LO:XD_PER_HI]}
    |=> sel_periph_q) else $error("peripheral window wrong");
  a_isp_follows_pins: assert property (in_system_prog_flag_q == ($past(mode_select_pins, 2) == MODE_ISP))
    else $error("programming flag does not follow mode pins");
  // Main scenarios reached
  c_rom_fetch: cover property (fetch_ack_q && rom_sel_q);
  c_unmapped_data: cover property (sel_none_q);
  c_refused_access: cover property (acc_miss_q);
endmodule

bind mmd_decoder mmd_decoder_props u_props (
  .clk, .rst_n, .mode_select_pins, .acc_req, .fetch_req, .fetch_addr, .xdata_req, .xdata_addr,
  .acc_ack_q, .acc_miss_q, .fetch_ack_q, .rom_sel_q, .nvm_sel_q, .rom_addr_q, .sel_ram_q,
  .sel_mac_reg_q, .sel_phy_q, .sel_periph_q, .sel_none_q, .xdata_off_q, .in_system_prog_flag_q
);

// >>> verif/mmd_core_model.sv
// Core model issuing accesses, fetches and data moves.
// Assumes the answer is registered one rising edge after a request.
`timescale 1ns/100ps
module mmd_core_model import mmd_pkg::*; (
  // Clock
  input wire logic    clk,
  // Internal access
  output logic        acc_req,
  output logic        acc_we,
  output mmd_kind_t   acc_kind,
  output logic [7:0]  acc_addr,
  output logic [7:0]  acc_wdata,
  // Fetch and external data
  output logic        fetch_req,
  output logic [15:0] fetch_addr,
  output logic        xdata_req,
  output logic [15:0] xdata_addr
);
  // ----------------------------------------------
  // Idle bus at time zero
  // ----------------------------------------------
  initial begin
    {acc_req, acc_we, fetch_req, xdata_req} = 4'h0;
    acc_kind = MMD_DIRECT;
    {acc_addr, acc_wdata} = 16'h0000;
    {fetch_addr, xdata_addr} = 32'h0000_0000;
  end
  // One access; released lines invert so stale data fails
  task automatic access(input logic we, input mmd_kind_t kind, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {acc_req, acc_we, acc_kind, acc_addr, acc_wdata} = {1'b1, we, kind, a, d};
    @(negedge clk);
    {acc_req, acc_addr, acc_wdata} = {1'b0, ~a, ~d};
  endtask
  // One instruction fetch
  task automatic fetch(input logic [15:0] a);
    @(negedge clk);
    {fetch_req, fetch_addr} = {1'b1, a};
    @(negedge clk);
    {fetch_req, fetch_addr} = {1'b0, ~a};
  endtask
  // Raised only for an external data move
  task automatic xdata(input logic [15:0] a);
    @(negedge clk);
    {xdata_req, xdata_addr} = {1'b1, a};
    @(negedge clk);
    {xdata_req, xdata_addr} = {1'b0, ~a};
  endtask
endmodule

// >>> verif/tb_top.sv
// Self-checking bench for the memory map decoder.
// Assumes requests change at falling edges.
`timescale 1ns/100ps
module tb_top import mmd_pkg::*;;
  logic                 clk = 1'b0;
  logic                 rst_n = 1'b0;
  logic [1:0]           mode_select_pins = 2'h0;
  logic                 acc_req, acc_we, fetch_req, xdata_req;
  mmd_kind_t            acc_kind;
  logic [7:0]           acc_addr, acc_wdata, acc_rdata_q;
  logic [15:0]          fetch_addr, xdata_addr, xdata_off_q;
  logic                 acc_ack_q, acc_miss_q, fetch_ack_q, rom_sel_q, nvm_sel_q, xdata_ack_q;
  logic                 sel_ram_q, sel_mac_reg_q, sel_phy_q, sel_mac_buf_q, sel_periph_q, sel_none_q;
  logic [PM_ROM_AW-1:0] rom_addr_q;
  logic [NVM_AW-1:0]    nvm_addr_q;
  logic [1:0]           working_bank_select_q;
  logic                 pointer_sel_q, in_system_prog_flag_q;
  int                   fail_count = 0;
  int                   num_checks = 0;
  localparam logic [15:0] XA [11] = '{16'h0000, 16'h1FFF, 16'h2000, 16'h21FF, 16'h2200, 16'h22FF,
                                      16'h2300, 16'h24FF, 16'h2500, 16'h27FF, 16'h2800};
  localparam logic [15:0] XB [6] = '{XD_RAM_LO, XD_MACR_LO, XD_PHY_LO, XD_MACB_LO, XD_PER_LO, 16'h0000};

  // Free-running 100 MHz clock
  always #5 clk = ~clk;

  mmd_core_model u_core (.clk, .acc_req, .acc_we, .acc_kind, .acc_addr, .acc_wdata,
    .fetch_req, .fetch_addr, .xdata_req, .xdata_addr);
  mmd_decoder u_dut (.clk, .rst_n, .mode_select_pins, .acc_req, .acc_we, .acc_kind, .acc_addr,
    .acc_wdata, .acc_ack_q, .acc_rdata_q, .acc_miss_q, .fetch_req, .fetch_addr, .fetch_ack_q,
    .rom_sel_q, .nvm_sel_q, .rom_addr_q, .nvm_addr_q, .xdata_req, .xdata_addr, .xdata_ack_q,
    .sel_ram_q, .sel_mac_reg_q, .sel_phy_q, .sel_mac_buf_q, .sel_periph_q, .sel_none_q,
    .xdata_off_q, .working_bank_select_q, .pointer_sel_q, .in_system_prog_flag_q);

  // ----------------------------------------------
  // Comparison and bus tasks
  // ----------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Read with expected data and miss flag
  task automatic rd(input mmd_kind_t k, input logic [7:0] a, input logic [7:0] exp, input logic m);
    u_core.access(1'b0, k, a, 8'h00);
    check({acc_ack_q, acc_miss_q, acc_rdata_q}, {1'b1, m, exp});
  endtask
  task automatic wr(input mmd_kind_t k, input logic [7:0] a, input logic [7:0] d);
    u_core.access(1'b1, k, a, d);
    check({acc_ack_q, acc_miss_q}, 2'b10);
  endtask
  // Fetch; nvm address checked even for ROM
  task automatic ft(input logic [15:0] a, input logic rom, input logic [NVM_AW-1:0] nvm);
    u_core.fetch(a);
    check({fetch_ack_q, rom_sel_q, nvm_sel_q, rom_addr_q, nvm_addr_q}, {1'b1, rom, !rom, a[9:0], nvm});
  endtask
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------------
  // Main sequence
  // ----------------------------------------------
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    check(working_bank_select_q, 2'h0);
    for (int i = 0; i < SFR_N; i++) begin
      rd(MMD_DIRECT, SFR_ADDR[i], SFR_RST[i], 1'b0);
    end
    rd(MMD_DIRECT, 8'h86, 8'h00, 1'b1);
    ft(16'hFC10, 1'b1, 17'h0FC10);
    ft(16'hFBFF, 1'b0, 17'h0FBFF);
    ft(16'h8004, 1'b0, 17'h08004);
    wr(MMD_DIRECT, 8'hA1, 8'h01);
    ft(16'h8004, 1'b0, 17'h10004);
    ft(16'h7FFF, 1'b0, 17'h07FFF);
    ft(16'hFFFF, 1'b1, 17'h17FFF);
    wr(MMD_DIRECT, 8'hC0, 8'h00);
    ft(16'hFFFF, 1'b0, 17'h17FFF);
    wr(MMD_DIRECT, 8'hA1, 8'h00);
    ft(16'hFC00, 1'b0, 17'h0FC00);
    // Bank 2 of working registers; select lags one cycle
    wr(MMD_DIRECT, 8'hA2, 8'hFF);
    wr(MMD_DIRECT, 8'hD0, 8'h10);
    @(negedge clk);
    check({working_bank_select_q, pointer_sel_q}, 3'h5);
    wr(MMD_WORKREG, 8'h03, 8'hA5);
    rd(MMD_DIRECT, 8'h13, 8'hA5, 1'b0);
    wr(MMD_BIT, 8'h0B, 8'h01);
    rd(MMD_DIRECT, 8'h21, 8'h08, 1'b0);
    wr(MMD_BIT, 8'h7F, 8'h01);
    rd(MMD_DIRECT, 8'h2F, 8'h80, 1'b0);
    rd(MMD_BIT, 8'h7F, 8'h01, 1'b0);
    wr(MMD_BIT, 8'hE2, 8'h01);
    rd(MMD_DIRECT, 8'hE0, 8'h04, 1'b0);
    wr(MMD_INDIRECT, 8'h7F, 8'h5A);
    rd(MMD_DIRECT, 8'h7F, 8'h5A, 1'b0);
    rd(MMD_INDIRECT, 8'h80, 8'h00, 1'b1);
    // Strap both mode pins high, then drop one
    mode_select_pins = 2'h3;
    repeat (2) @(negedge clk);
    rd(MMD_DIRECT, 8'hC0, 8'h04, 1'b0);
    mode_select_pins = 2'h1;
    repeat (2) @(negedge clk);
    check(in_system_prog_flag_q, 1'b0);
    // Both edges of every data window, then past the map
    for (int i = 0; i < 11; i++) begin
      u_core.xdata(XA[i]);
      check({xdata_ack_q, sel_ram_q, sel_mac_reg_q, sel_phy_q, sel_mac_buf_q, sel_periph_q, sel_none_q,
        xdata_off_q}, {1'b1, 6'h20 >> (i / 2), XA[i] - XB[i / 2]});
    end
    report_and_stop;
  end
endmodule
